// ===== design/gtib_pad_store.sv
// Per-line pad settings and function-select storage, loaded by bulk commands
`timescale 1ns/10ps
module gtib_pad_store #(
    parameter int LINES = 32
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           ce,
    input  wire gtib_pkg::gtib_bulk_cmd_t       cmd,
    output gtib_pkg::gtib_pad_cfg_t [LINES-1:0] pad_cfg,
    output logic [LINES-1:0][3:0]               func_sel
);

    typedef struct packed {
        gtib_pkg::gtib_pad_cfg_t [LINES-1:0] cfg;
        logic [LINES-1:0][3:0]               fs;
    } gtib_store_st_t;

    gtib_store_st_t st_ff;
    gtib_store_st_t nxt_st;

    generate
        if (LINES != 32)
        begin : g_bad_lines
            $error("gtib_pad_store serves exactly two halves of sixteen lines");
        end
    endgenerate

    always_comb
    begin
        logic sel;
        sel = 1'b0;
        nxt_st = st_ff;
        for (int i = 0; i < LINES; i++)
        begin
            sel = cmd.valid && (cmd.half_select == (i >= LINES / 2))
                  && cmd.line_select_mask[i % (LINES / 2)];
            if (sel && cmd.apply_pad_settings)
                nxt_st.cfg[i] = cmd.pad_settings;
            if (sel && cmd.apply_function_select)
                nxt_st.fs[i] = cmd.function_select_code;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff.cfg <= {LINES{gtib_pkg::PAD_CFG_RST}};
            st_ff.fs  <= {LINES{gtib_pkg::FSEL_RST}};
        end
        else if (ce)
            st_ff <= nxt_st;
    end

    assign pad_cfg  = st_ff.cfg;
    assign func_sel = st_ff.fs;

    a_cfg_low_load: assert property (
        @(posedge clk) disable iff (rst)
        ce && cmd.valid && cmd.apply_pad_settings && !cmd.half_select
            && cmd.line_select_mask[0]
        |=> pad_cfg[0] == $past(cmd.pad_settings))
        else $error("Selected low line missed its pad settings");

    a_fs_upper_load: assert property (
        @(posedge clk) disable iff (rst)
        ce && cmd.valid && cmd.apply_function_select && cmd.half_select
            && cmd.line_select_mask[15]
        |=> func_sel[LINES-1] == $past(cmd.function_select_code))
        else $error("Selected upper line missed its function code");

    a_cfg_no_strobe: assert property (
        @(posedge clk) disable iff (rst)
        ce && cmd.valid && !cmd.apply_pad_settings |=> $stable(pad_cfg))
        else $error("Pad settings changed without their strobe");

    a_both_same_cycle: assert property (
        @(posedge clk) disable iff (rst)
        ce && cmd.valid && cmd.apply_pad_settings && cmd.apply_function_select
            && !cmd.half_select && cmd.line_select_mask[1]
        |=> pad_cfg[1] == $past(cmd.pad_settings)
            && func_sel[1] == $past(cmd.function_select_code))
        else $error("Combined bulk write did not land in one cycle");

    a_other_half_kept: assert property (
        @(posedge clk) disable iff (rst)
        ce && cmd.valid && !cmd.half_select
        |=> $stable(pad_cfg[LINES-1]) && $stable(func_sel[LINES-1]))
        else $error("Lower half write touched an upper line");

endmodule : gtib_pad_store

// ===== design/gtib_pkg.sv
// Shared constants, carrier types and helper functions for the port group block
package gtib_pkg;

    localparam logic [7:0]  FLIP_OFS      = 8'h1c;
    localparam logic [7:0]  SAMPLED_OFS   = 8'h20;
    localparam logic [7:0]  SAMPCTRL_OFS  = 8'h24;
    localparam logic [7:0]  BULK_OFS      = 8'h28;

    localparam logic [31:0] OUT_RST       = 32'h0000_0000;
    localparam logic [31:0] SAMPLED_RST   = 32'h0000_0000;
    localparam logic [31:0] SAMPCTRL_RST  = 32'h0000_0000;
    localparam logic [3:0]  FSEL_RST      = 4'h0;
    localparam logic [3:0]  FULL_STRB     = 4'hf;

    localparam int HALF_BIT    = 31;
    localparam int CFG_STB_BIT = 30;
    localparam int FS_STB_BIT  = 28;
    localparam int FS_LSB      = 24;
    localparam int STRONG_BIT  = 22;
    localparam int PULL_BIT    = 18;
    localparam int BUF_BIT     = 17;
    localparam int ALT_BIT     = 16;
    localparam int MASK_LSB    = 0;

    typedef struct packed {
        logic strong_drive;
        logic pull_resistor_enable;
        logic sample_buffer_enable;
        logic alt_function_enable;
    } gtib_pad_cfg_t;

    localparam gtib_pad_cfg_t PAD_CFG_RST = 4'h0;

    typedef struct packed {
        logic          valid;
        logic          half_select;
        logic          apply_pad_settings;
        logic          apply_function_select;
        logic [3:0]    function_select_code;
        gtib_pad_cfg_t pad_settings;
        logic [15:0]   line_select_mask;
    } gtib_bulk_cmd_t;

    // Split a full bulk write word into its command fields
    function automatic gtib_bulk_cmd_t gtib_decode_bulk(input logic [31:0] w, input logic v);
        gtib_bulk_cmd_t c;
        c.valid                                  = v;
        c.half_select                            = w[HALF_BIT];
        c.apply_pad_settings                     = w[CFG_STB_BIT];
        c.apply_function_select                  = w[FS_STB_BIT];
        c.function_select_code                   = w[FS_LSB +: 4];
        c.pad_settings.strong_drive              = w[STRONG_BIT];
        c.pad_settings.pull_resistor_enable      = w[PULL_BIT];
        c.pad_settings.sample_buffer_enable      = w[BUF_BIT];
        c.pad_settings.alt_function_enable       = w[ALT_BIT];
        c.line_select_mask                       = w[MASK_LSB +: 16];
        return c;
    endfunction : gtib_decode_bulk

    // Expand byte strobes to a bit mask
    function automatic logic [31:0] gtib_strb_mask(input logic [3:0] s);
        logic [31:0] m;
        m = 32'h0;
        for (int b = 0; b < 4; b++)
            m[b*8 +: 8] = {8{s[b]}};
        return m;
    endfunction : gtib_strb_mask

    // Any set bit in a byte turns the whole byte on
    function automatic logic [31:0] gtib_byte_group(input logic [31:0] c);
        logic [31:0] g;
        g = 32'h0;
        for (int b = 0; b < 4; b++)
            g[b*8 +: 8] = {8{|c[b*8 +: 8]}};
        return g;
    endfunction : gtib_byte_group

endpackage : gtib_pkg

// ===== design/gtib_port.sv
// Port group top: toggle view, sampled levels, sampler control and bulk pad setup over APB
`timescale 1ns/10ps
module gtib_port #(
    parameter int LINES = 32
) (
    input  wire logic                           clk,
    input  wire logic                           rst,
    input  wire logic                           ce,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    input  wire logic [3:0]                     pstrb,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [LINES-1:0]               dir_out,
    input  wire logic [LINES-1:0]               pad_in,
    output logic      [LINES-1:0]               drive_level,
    output logic      [LINES-1:0]               pull_up,
    output logic      [LINES-1:0]               pull_down,
    output logic      [LINES-1:0]               sampler_active,
    output gtib_pkg::gtib_pad_cfg_t [LINES-1:0] pad_cfg,
    output logic [LINES-1:0][3:0]               func_sel
);

    typedef struct packed {
        logic [31:0] out_level;
        logic [31:0] in_level;
        logic [31:0] samp_ctrl;
        logic [31:0] samp_on;
        logic [31:0] pull_up;
        logic [31:0] pull_down;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } gtib_port_st_t;

    localparam gtib_port_st_t ST_RST = '{
        out_level: gtib_pkg::OUT_RST,
        in_level:  gtib_pkg::SAMPLED_RST,
        samp_ctrl: gtib_pkg::SAMPCTRL_RST,
        samp_on:   32'h0,
        pull_up:   32'h0,
        pull_down: 32'h0,
        prdata:    32'h0,
        pready:    1'b0,
        pslverr:   1'b0
    };

    gtib_port_st_t            st_ff;
    gtib_port_st_t            nxt_st;
    gtib_pkg::gtib_bulk_cmd_t bulk_cmd;
    logic [31:0]              sync_q;
    logic [31:0]              buf_en;
    logic [31:0]              pull_en;
    logic [31:0]              upd;
    logic [31:0]              wmask;
    logic                     setup;
    logic                     acc1;
    logic                     done;
    logic                     hit_flip;
    logic                     hit_sampled;
    logic                     hit_ctrl;
    logic                     hit_bulk;
    logic                     hit_any;

    generate
        if (LINES != 32)
        begin : g_bad_lines
            $error("gtib_port registers are one 32-bit word per group");
        end
    endgenerate

    gtib_sync2 #(
        .WIDTH (LINES)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .ce  (ce),
        .d   (pad_in),
        .q   (sync_q)
    );

    gtib_pad_store #(
        .LINES (LINES)
    ) u_store (
        .clk      (clk),
        .rst      (rst),
        .ce       (ce),
        .cmd      (bulk_cmd),
        .pad_cfg  (pad_cfg),
        .func_sel (func_sel)
    );

    always_comb
    begin
        for (int i = 0; i < LINES; i++)
        begin
            buf_en[i]  = pad_cfg[i].sample_buffer_enable;
            pull_en[i] = pad_cfg[i].pull_resistor_enable;
        end
    end

    // One wait state: access cycle one loads the answer, cycle two completes
    assign setup       = psel && !penable;
    assign acc1        = psel && penable && !st_ff.pready;
    assign done        = psel && penable && st_ff.pready;
    assign hit_flip    = paddr == gtib_pkg::FLIP_OFS;
    assign hit_sampled = paddr == gtib_pkg::SAMPLED_OFS;
    assign hit_ctrl    = paddr == gtib_pkg::SAMPCTRL_OFS;
    assign hit_bulk    = paddr == gtib_pkg::BULK_OFS;
    assign hit_any     = hit_flip || hit_sampled || hit_ctrl || hit_bulk;
    assign wmask       = gtib_pkg::gtib_strb_mask(pstrb);

    // Only a full-word write reaches the store, so narrow accesses cannot split it
    assign bulk_cmd = gtib_pkg::gtib_decode_bulk(pwdata,
                          done && pwrite && hit_bulk && pstrb == gtib_pkg::FULL_STRB);

    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.pready = acc1;
        if (acc1)
        begin
            nxt_st.pslverr = !hit_any;
            nxt_st.prdata  = 32'h0;
            if (!pwrite && hit_flip)
                nxt_st.prdata = st_ff.out_level;
            else if (!pwrite && hit_sampled)
                nxt_st.prdata = st_ff.in_level;
            // Sampler control and bulk setup are write-only and read zero
        end
        else
        begin
            // Read data and error only stand while ready does
            nxt_st.pslverr = 1'b0;
            nxt_st.prdata  = 32'h0;
        end

        if (done && pwrite && hit_flip)
            nxt_st.out_level = st_ff.out_level ^ (pwdata & wmask);
        if (done && pwrite && hit_ctrl)
            nxt_st.samp_ctrl = (st_ff.samp_ctrl & ~wmask) | (pwdata & wmask);

        // Outputs sample whenever buffered; inputs only when their byte asks
        nxt_st.samp_on = buf_en & (dir_out | gtib_pkg::gtib_byte_group(st_ff.samp_ctrl));

        // A read of the sampled view also samples buffered lines on demand
        upd = st_ff.samp_on;
        if (setup && !pwrite && hit_sampled)
            upd = upd | buf_en;
        nxt_st.in_level = (st_ff.in_level & ~upd) | (sync_q & upd);

        // Output latch doubles as pull direction on pulled inputs
        nxt_st.pull_up   = pull_en & ~dir_out & nxt_st.out_level;
        nxt_st.pull_down = pull_en & ~dir_out & ~nxt_st.out_level;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_ff <= ST_RST;
        else if (ce)
            st_ff <= nxt_st;
    end

    assign prdata         = st_ff.prdata;
    assign pready         = st_ff.pready;
    assign pslverr        = st_ff.pslverr;
    assign drive_level    = st_ff.out_level;
    assign pull_up        = st_ff.pull_up;
    assign pull_down      = st_ff.pull_down;
    assign sampler_active = st_ff.samp_on;

    sequence s_bulk_read;
        ce && psel && !penable && !pwrite && hit_bulk
        ##1 ce && psel && penable && !pwrite && hit_bulk;
    endsequence

    sequence s_full_flip;
        ce && done && pwrite && hit_flip && pstrb == gtib_pkg::FULL_STRB;
    endsequence

    sequence s_access_start;
        ce && setup
        ##1 ce && acc1;
    endsequence

    sequence s_ctrl_write;
        ce && done && pwrite && hit_ctrl && pstrb == gtib_pkg::FULL_STRB;
    endsequence

    a_toggle_flip: assert property (
        @(posedge clk) disable iff (rst)
        s_full_flip |=> drive_level == ($past(drive_level) ^ $past(pwdata)))
        else $error("Toggle write did not invert exactly the written ones");

    a_pull_swap: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> pull_up == ($past(pull_en) & ~$past(dir_out) & drive_level)
            && (pull_up & pull_down) == 32'h0)
        else $error("Pull direction does not follow the output latch");

    a_in_capture: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> ((st_ff.in_level ^ $past(sync_q)) & $past(st_ff.samp_on)) == 32'h0)
        else $error("Sampled level differs from synchronised pad");

    a_in_reset_zero: assert property (
        @(posedge clk)
        $fell(rst) |-> st_ff.in_level == 32'h0)
        else $error("Sampled register not zero after reset");

    a_byte_group_on: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> (sampler_active & ~$past(dir_out))
            == ($past(buf_en) & ~$past(dir_out)
                & gtib_pkg::gtib_byte_group($past(st_ff.samp_ctrl))))
        else $error("Input samplers not switched per byte");

    a_bulk_narrow_drop: assert property (
        @(posedge clk) disable iff (rst)
        ce && done && pwrite && hit_bulk && pstrb != gtib_pkg::FULL_STRB
        |=> $stable(pad_cfg) && $stable(func_sel))
        else $error("Narrow bulk write changed the configuration");

    a_bulk_read_zero: assert property (
        @(posedge clk) disable iff (rst)
        s_bulk_read |=> pready && prdata == 32'h0)
        else $error("Bulk register read returned nonzero");

    a_ready_pulse: assert property (
        @(posedge clk) disable iff (rst)
        ce && pready |=> !pready)
        else $error("Ready stood longer than one cycle");

    a_ready_after_access: assert property (
        @(posedge clk) disable iff (rst)
        s_access_start |=> pready)
        else $error("Ready missing after the first access cycle");

    a_ready_needs_access: assert property (
        @(posedge clk) disable iff (rst)
        ce && !(psel && penable) |=> !pready)
        else $error("Ready raised outside an access");

    a_unmapped_error: assert property (
        @(posedge clk) disable iff (rst)
        ce && acc1 && !hit_any
        |=> pready && pslverr)
        else $error("Unmapped access completed without error");

    a_mapped_no_error: assert property (
        @(posedge clk) disable iff (rst)
        ce && acc1 && hit_any
        |=> pready && !pslverr)
        else $error("Mapped access flagged an error");

    a_idle_bus_quiet: assert property (
        @(posedge clk) disable iff (rst)
        !pready |-> prdata == 32'h0 && !pslverr)
        else $error("Read data or error shown without ready");

    a_flip_zero_keep: assert property (
        @(posedge clk) disable iff (rst)
        ce && done && pwrite && hit_flip
        |=> ((drive_level ^ $past(drive_level)) & ~$past(pwdata)) == 32'h0)
        else $error("Toggle write changed a line written as zero");

    a_out_no_write_hold: assert property (
        @(posedge clk) disable iff (rst)
        ce && !(done && pwrite && hit_flip)
        |=> $stable(drive_level))
        else $error("Output latch moved without a toggle write");

    a_pull_inputs_only: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> ((pull_up | pull_down) & $past(dir_out)) == 32'h0)
        else $error("Pull applied to an output line");

    a_unsampled_hold: assert property (
        @(posedge clk) disable iff (rst)
        ce && !(setup && !pwrite && hit_sampled)
        |=> ((st_ff.in_level ^ $past(st_ff.in_level)) & ~$past(st_ff.samp_on)) == 32'h0)
        else $error("Unsampled line changed its sampled level");

    a_demand_sample: assert property (
        @(posedge clk) disable iff (rst)
        ce && setup && !pwrite && hit_sampled
        |=> ((st_ff.in_level ^ $past(sync_q)) & $past(buf_en)) == 32'h0)
        else $error("Read did not sample the buffered lines");

    a_ctrl_full_write: assert property (
        @(posedge clk) disable iff (rst)
        s_ctrl_write |=> st_ff.samp_ctrl == $past(pwdata))
        else $error("Sampler control write did not land");

    a_ctrl_no_write_hold: assert property (
        @(posedge clk) disable iff (rst)
        ce && !(done && pwrite && hit_ctrl)
        |=> $stable(st_ff.samp_ctrl))
        else $error("Sampler control moved without a write");

    a_output_lines_sampled: assert property (
        @(posedge clk) disable iff (rst)
        ce |=> (sampler_active & $past(dir_out)) == ($past(buf_en) & $past(dir_out)))
        else $error("Buffered output line not sampled");

endmodule : gtib_port

// ===== design/gtib_sync2.sv
// Two-flop synchroniser for the pad input levels
`timescale 1ns/10ps
module gtib_sync2 #(
    parameter int WIDTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } gtib_sync_st_t;

    gtib_sync_st_t st_ff;
    gtib_sync_st_t nxt_st;

    generate
        if (WIDTH < 1)
        begin : g_bad_width
            $error("gtib_sync2 width must be at least one");
        end
    endgenerate

    always_comb
    begin
        nxt_st.meta = d;
        nxt_st.held = st_ff.meta;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            st_ff <= '0;
        else if (ce)
            st_ff <= nxt_st;
    end

    assign q = st_ff.held;

endmodule : gtib_sync2

// ===== dv/gtib_port_tb.sv
// Self-checking testbench for the port group block
`timescale 1ns/10ps
module gtib_port_tb;
    logic                           clk = 1'b0;
    logic                           rst = 1'b1;
    logic                           ce = 1'b1;
    logic                           psel = 1'b0;
    logic                           penable = 1'b0;
    logic                           pwrite = 1'b0;
    logic [7:0]                     paddr = 8'h00;
    logic [31:0]                    pwdata = 32'h0;
    logic [3:0]                     pstrb = 4'h0;
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    dir_out = 32'h0;
    logic [31:0]                    pad_in = 32'h0;
    logic [31:0]                    drive_level;
    logic [31:0]                    pull_up;
    logic [31:0]                    pull_down;
    logic [31:0]                    sampler_active;
    gtib_pkg::gtib_pad_cfg_t [31:0] pad_cfg;
    logic [31:0][3:0]               func_sel;
    logic [31:0][3:0]               exp_cfg = '0;
    logic [31:0][3:0]               exp_fs = '0;
    logic [31:0]                    exp_drv = 32'h0;
    logic [31:0]                    rd;
    logic                           er;
    int                             err_total = 0;
    int                             n_compared = 0;

    always #25 clk = ~clk;

    gtib_port #(.LINES(32)) i_dut (
        .clk(clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dir_out(dir_out), .pad_in(pad_in), .drive_level(drive_level),
        .pull_up(pull_up), .pull_down(pull_down), .sampler_active(sampler_active),
        .pad_cfg(pad_cfg), .func_sel(func_sel)
    );

    task automatic final_report();
        if (err_total == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    // One APB transfer; holds the request until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        // Wait for the answer; only the watchdog ends a hung transfer
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1);
        chk("access cycles", n, 32'd2);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(negedge clk);
    endtask : apb

    function automatic logic [31:0] bw(input logic h, input logic ps, input logic fs,
                                       input logic [3:0] code, input logic [3:0] cfg,
                                       input logic [15:0] m);
        return {h, ps, 1'b0, fs, code, 1'b0, cfg[3], 3'b000, cfg[2:0], m};
    endfunction : bw

    task automatic model_bulk(input logic [31:0] w);
        int idx;
        for (int i = 0; i < 16; i++)
        begin
            idx = w[31] ? i + 16 : i;
            if (w[i] && w[30])
                exp_cfg[idx] = {w[22], w[18:16]};
            if (w[i] && w[28])
                exp_fs[idx] = w[27:24];
        end
    endtask : model_bulk

    task automatic chk_store();
        for (int i = 0; i < 32; i++)
        begin
            chk("pad_cfg", pad_cfg[i], exp_cfg[i]);
            chk("func_sel", func_sel[i], exp_fs[i]);
        end
    endtask : chk_store

    task automatic chk_pull();
        logic [31:0] pe;
        for (int i = 0; i < 32; i++)
            pe[i] = exp_cfg[i][2];
        chk("pull_up", pull_up, pe & ~dir_out & exp_drv);
        chk("pull_down", pull_down, pe & ~dir_out & ~exp_drv);
    endtask : chk_pull

    task automatic t_reset();
        apb(1'b0, 8'h20, 32'h0, 4'h0);
        chk("sampled after reset", rd, 32'h0);
        apb(1'b0, 8'h24, 32'h0, 4'h0);
        chk("sampler control read", rd, 32'h0);
        apb(1'b0, 8'h28, 32'h0, 4'h0);
        chk("bulk read", rd, 32'h0);
        chk("drive_level", drive_level, 32'h0);
        chk_store();
    endtask : t_reset

    task automatic t_toggle();
        logic [31:0] d [4] = '{32'ha5a5_00ff, 32'h0000_00f0, 32'h0, 32'hffff_ffff};
        logic [3:0]  s [4] = '{4'hf, 4'hf, 4'hf, 4'h2};
        logic [31:0] m [4] = '{32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff, 32'h0000_ff00};
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 8'h1c, d[i], s[i]);
            exp_drv = exp_drv ^ (d[i] & m[i]);
            chk("drive_level", drive_level, exp_drv);
        end
        apb(1'b0, 8'h1c, 32'h0, 4'h0);
        chk("toggle readback", rd, exp_drv);
    endtask : t_toggle

    task automatic t_pull();
        apb(1'b1, 8'h28, bw(1'b0, 1'b1, 1'b0, 4'h0, 4'b0100, 16'h0003), 4'hf);
        model_bulk(bw(1'b0, 1'b1, 1'b0, 4'h0, 4'b0100, 16'h0003));
        repeat (2) @(negedge clk);
        chk_pull();
        apb(1'b1, 8'h1c, 32'h0000_0001, 4'hf);
        exp_drv = exp_drv ^ 32'h1;
        repeat (2) @(negedge clk);
        chk_pull();
        @(posedge clk);
        dir_out <= 32'h0000_0002;
        repeat (2) @(negedge clk);
        chk_pull();
    endtask : t_pull

    task automatic t_bulk();
        logic [31:0] w [6];
        logic [3:0]  s [6] = '{4'hf, 4'hf, 4'hf, 4'h3, 4'h1, 4'hf};
        w[0] = bw(1'b0, 1'b1, 1'b1, 4'h5, 4'b1001, 16'h00f0);
        w[1] = bw(1'b1, 1'b0, 1'b1, 4'h3, 4'b1111, 16'h8001);
        w[2] = bw(1'b1, 1'b1, 1'b0, 4'h7, 4'b0110, 16'h0101);
        w[3] = bw(1'b0, 1'b1, 1'b1, 4'h2, 4'b1111, 16'hffff);
        w[4] = bw(1'b1, 1'b1, 1'b1, 4'h2, 4'b1111, 16'hffff);
        w[5] = bw(1'b0, 1'b1, 1'b1, 4'h8, 4'b1111, 16'h0000);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 8'h28, w[i], s[i]);
            chk("bulk write error", er, 1'b0);
            if (s[i] == 4'hf)
                model_bulk(w[i]);
            chk_store();
        end
        for (int c = 0; c < 16; c++)
        begin
            apb(1'b1, 8'h28, bw(1'b1, 1'b0, 1'b1, c[3:0], 4'h0, 16'h1 << c), 4'hf);
            model_bulk(bw(1'b1, 1'b0, 1'b1, c[3:0], 4'h0, 16'h1 << c));
        end
        chk_store();
        apb(1'b0, 8'h28, 32'h0, 4'h0);
        chk("bulk read", rd, 32'h0);
    endtask : t_bulk

    task automatic t_sample();
        logic [31:0] c [3] = '{32'h0000_0100, 32'h8000_0000, 32'h0};
        logic [31:0] e [3] = '{32'h00ff_ff00, 32'hffff_0000, 32'h00ff_0000};
        for (int h = 0; h < 2; h++)
        begin
            apb(1'b1, 8'h28, bw(h[0], 1'b1, 1'b0, 4'h0, 4'b0010, 16'hffff), 4'hf);
            model_bulk(bw(h[0], 1'b1, 1'b0, 4'h0, 4'b0010, 16'hffff));
        end
        @(posedge clk);
        dir_out <= 32'h00ff_0000;
        for (int i = 0; i < 3; i++)
        begin
            apb(1'b1, 8'h24, c[i], 4'hf);
            repeat (2) @(negedge clk);
            // All lines have the buffer enabled here
            chk("sampler_active", sampler_active, e[i]);
        end
        @(posedge clk);
        pad_in <= 32'h1234_5678;
        repeat (4) @(negedge clk);
        apb(1'b0, 8'h20, 32'h0, 4'h0);
        chk("sampled level", rd, 32'h1234_5678);
        @(posedge clk);
        pad_in <= 32'hedcb_a987;
        repeat (4) @(negedge clk);
        apb(1'b1, 8'h20, 32'h0, 4'hf);
        chk("sampled write error", er, 1'b0);
        apb(1'b0, 8'h20, 32'h0, 4'h0);
        chk("sampled level", rd, 32'hedcb_a987);
        apb(1'b0, 8'h40, 32'h0, 4'h0);
        chk("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
    endtask : t_sample

    // Clock enable low must hold every register, then release it
    task automatic t_freeze();
        @(posedge clk);
        ce      <= 1'b0;
        dir_out <= 32'hffff_ffff;
        repeat (3) @(negedge clk);
        chk("frozen sampler_active", sampler_active, 32'h00ff_0000);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(negedge clk);
        chk("sampler_active", sampler_active, 32'hffff_ffff);
    endtask : t_freeze

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_toggle();
        t_pull();
        t_bulk();
        t_sample();
        t_freeze();
        final_report();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report();
    end
endmodule : gtib_port_tb
